// *** bench/adc_oversampling_filter_tb.sv ***
// self-checking bench of the adc oversampling filter block
`timescale 1ns/10ps
module adc_oversampling_filter_tb;
    // ----
    // signals
    // ----
    logic core_clk;
    logic rst_n;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    adc_filt_pkg::conv_t conv;
    logic [3:0] cmp_sample_use, cmp_hit, use_exp;
    logic adc_irq_req, irq;
    int error_cnt, compares;
    logic [31:0] seed; // xorshift state
    logic [25:0] mask [4]; // bench copy of comparator masks
    logic [4:0] last_evt [4]; // last event channel per comparator
    logic [7:0] exp_stat, imask; // expected irq status and mask

    adc_filter_top adc_filter_top_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv(conv), .cmp_sample_use(cmp_sample_use),
        .cmp_hit(cmp_hit), .adc_irq_req(adc_irq_req), .irq(irq));
    conv_source conv_source_i (.core_clk(core_clk), .conv(conv), .cmp_hit(cmp_hit));

    // 20 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ----
    // helpers
    // ----
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] base(input int i);
        return 8'(i) * adc_filt_pkg::INST_STRIDE;
    endfunction

    task automatic give_verdict();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; the wait for pready is bounded
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk("write error flag", {31'h0, e}, 32'h0);
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, r, exp);
        chk("read error flag", {31'h0, e}, 32'h0);
    endtask

    // ----
    // comparator side monitor: use flags and event bookkeeping
    // ----
    always @(negedge core_clk) begin
        if (conv.valid === 1'b1) begin
            for (int j = 0; j < 4; j++) begin
                use_exp[j] = mask[j][conv.chan];
            end
            chk("comparator use", {28'h0, cmp_sample_use}, {28'h0, use_exp});
            for (int j = 0; j < 4; j++) begin
                if (use_exp[j] & cmp_hit[j]) begin
                    last_evt[j] = conv.chan;
                    exp_stat[4+j] = 1'b1;
                end
            end
        end
    end

    // ----
    // one filter run: configure, feed, check result, ready and interrupts
    // ----
    task automatic run(input int i, input logic [1:0] m, input logic [2:0] c, input logic kill);
        logic [4:0] sel;
        logic [20:0] sum;
        logic [11:0] d;
        logic [15:0] cw;
        logic [7:0] ca;
        int k;
        sel = (c < 2) ? 5'(24 + c) : 5'(rnd() % 26);
        k = (m == adc_filt_pkg::MODE_AVERAGE) ? c + 1 : (c[2] ? 2*c[1:0] + 1 : 2*c[1:0] + 2);
        cw = {1'b1, m, c, c[0], 1'b0, 3'h0, sel};
        ca = base(i) + adc_filt_pkg::OFS_FILT_CTRL;
        sum = '0;
        wr(ca, {16'h0, cw});
        for (int n = 0; n < (1 << k); n++) begin
            d = (c == 3'h3) ? 12'hfff : 12'(rnd());
            if (rnd() % 4 == 0) begin
                // a result of another channel must not be accumulated
                conv_source_i.put((sel == 5'd25) ? 5'd0 : sel + 5'd1, 12'(rnd()), 4'(rnd()), 0);
            end
            conv_source_i.put(sel, d, 4'(rnd()), int'(rnd() % 3));
            sum += 21'(d);
        end
        exp_stat[i] = 1'b1;
        if (kill) begin
            wr(ca, {16'h0, cw & 16'h7fff});
            rchk("ready after off", ca, {16'h0, cw & 16'h7fff});
            chk("irq request off", {31'h0, adc_irq_req}, 32'h0);
        end else begin
            rchk("ready set", ca, {16'h0, cw | 16'h0100});
            chk("irq request", {31'h0, adc_irq_req}, {31'h0, c[0]});
            chk("irq line", {31'h0, irq}, {31'h0, |(exp_stat & imask)});
            rchk("irq status", adc_filt_pkg::OFS_IRQ_STATUS, {24'h0, exp_stat});
            exp_stat = 8'h00;
            rchk("result", base(i) + adc_filt_pkg::OFS_FILT_DATA,
                 {11'h0, (m == adc_filt_pkg::MODE_AVERAGE) ? sum >> k : sum >> (k / 2)});
            rchk("ready cleared", ca, {16'h0, cw});
            chk("irq request gone", {31'h0, adc_irq_req}, 32'h0);
            wr(ca, 32'h0);
        end
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        logic [31:0] r;
        logic e;
        seed = 32'h0000_0060;
        error_cnt = 0;
        compares = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_n = 1'b0;
        exp_stat = 8'h00;
        for (int j = 0; j < 4; j++) begin
            mask[j] = '0;
            last_evt[j] = '0;
        end
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rchk("ctrl reset", base(i), 32'h0);
            rchk("mask low reset", base(i) + adc_filt_pkg::OFS_MASK_LOW, 32'h0);
            rchk("mask high reset", base(i) + adc_filt_pkg::OFS_MASK_HIGH, 32'h0);
        end
        rchk("status reset", adc_filt_pkg::OFS_IRQ_STATUS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            mask[i] = 26'(rnd());
            wr(base(i) + adc_filt_pkg::OFS_MASK_LOW, {16'h0, mask[i][15:0]});
            wr(base(i) + adc_filt_pkg::OFS_MASK_HIGH, {16'h0, 6'h3f, mask[i][25:16]});
            rchk("mask low", base(i) + adc_filt_pkg::OFS_MASK_LOW,
                 {16'h0, mask[i][15:0]});
            rchk("mask high", base(i) + adc_filt_pkg::OFS_MASK_HIGH,
                 {22'h0, mask[i][25:16]});
        end
        wr(base(2), 32'h0000_7fff);
        rchk("ctrl spare bits", base(2), 32'h0000_7e1f);
        wr(base(2), 32'h0);
        imask = 8'(rnd());
        wr(adc_filt_pkg::OFS_IRQ_MASK, {24'h0, imask});
        rchk("irq mask", adc_filt_pkg::OFS_IRQ_MASK, {24'h0, imask});
        apb(1'b0, 8'h58, 32'h0, r, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        apb(1'b1, 8'h02, 32'hffff, r, e);
        chk("unaligned error", {31'h0, e}, 32'h1);
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 8; c++) begin
                run(c % 4, m ? adc_filt_pkg::MODE_AVERAGE : adc_filt_pkg::MODE_OVERSAMPLE,
                    3'(c), 1'b0);
            end
        end
        run(3, adc_filt_pkg::MODE_OVERSAMPLE, 3'h5, 1'b1);
        for (int j = 0; j < 4; j++) begin
            rchk("event channel", adc_filt_pkg::OFS_EVT_CHAN + 8'(4*j),
                 {27'h0, last_evt[j]});
        end
        // the killed run still left its completion and any comparator events pending
        rchk("irq status end", adc_filt_pkg::OFS_IRQ_STATUS, {24'h0, exp_stat});
        give_verdict();
    end

    // a hang ends the run as a failure
    initial begin
        #5000000;
        error_cnt++;
        give_verdict();
    end
endmodule

// *** bench/conv_source.sv ***
// behavioural model of the adc cores feeding conversion results
`timescale 1ns/10ps
module conv_source (
    // clock
    input wire logic core_clk,
    // results and threshold comparator hits
    output adc_filt_pkg::conv_t conv,
    output logic [3:0] cmp_hit
);
    // idle at time zero
    initial begin
        conv = '0;
        cmp_hit = 4'h0;
    end

    // one result strobe; between strobes the lines show the inverse of the
    // last value so that stale data can never pass for fresh data
    task automatic put(input logic [4:0] chan, input logic [11:0] data, input logic [3:0] hit,
                       input int gap);
        @(posedge core_clk);
        conv <= '{valid: 1'b1, chan: chan, data: data};
        cmp_hit <= hit;
        @(posedge core_clk);
        conv <= '{valid: 1'b0, chan: ~chan, data: ~data};
        cmp_hit <= ~hit;
        repeat (gap) @(posedge core_clk);
    endtask
endmodule

// *** hw/adc_filt_pkg.sv ***
// constants, register map and carrier types of the adc oversampling filter block
package adc_filt_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_INST = 4;          // filter and comparator instances
    localparam int NUM_CHAN = 26;         // analog inputs incl. temp and band-gap
    localparam int SAMPLE_W = 12;
    localparam int ACC_W = 20;            // 12 bits plus 256 samples
    localparam int CNT_W = 9;

    // ------------------------------------------------------------------
    // apb register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] INST_STRIDE = 8'h10;    // one block of four words per instance
    localparam logic [7:0] OFS_FILT_CTRL = 8'h00;
    localparam logic [7:0] OFS_FILT_DATA = 8'h04;
    localparam logic [7:0] OFS_MASK_LOW = 8'h08;
    localparam logic [7:0] OFS_MASK_HIGH = 8'h0c;
    localparam logic [7:0] OFS_EVT_CHAN = 8'h40;   // plus 4 per comparator
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h50;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h54;

    // ------------------------------------------------------------------
    // filter control fields
    // ------------------------------------------------------------------
    localparam int CTRL_ON_BIT = 15;
    localparam int CTRL_MODE_LSB = 13;
    localparam int CTRL_RATIO_LSB = 10;
    localparam int CTRL_IRQ_BIT = 9;
    localparam int CTRL_RDY_BIT = 8;
    localparam int CTRL_SEL_LSB = 0;
    localparam int MASK_HIGH_W = 10;                // channels 16..25
    localparam logic [1:0] MODE_OVERSAMPLE = 2'h0;
    localparam logic [1:0] MODE_AVERAGE = 2'h3;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // log2 of the oversampling count, indexed by the ratio code
    localparam logic [7:0][3:0] OVS_LOG2 = {4'h7, 4'h5, 4'h3, 4'h1, 4'h8, 4'h6, 4'h4, 4'h2};

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;                       // one-cycle strobe of a new result
        logic [4:0] chan;                  // channel number of the result
        logic [SAMPLE_W-1:0] data;
    } conv_t;

    typedef struct packed {
        logic filter_on;
        logic [1:0] mode;
        logic [2:0] sample_ratio_sel;
        logic filter_irq_allow;
        logic [4:0] filter_input_sel;
    } filt_cfg_t;

endpackage

// *** hw/adc_filter_top.sv ***
// adc post-conversion logic: four oversampling filters and comparator channel masks
`timescale 1ns/10ps
module adc_filter_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // conversion results from the adc cores
    input wire adc_filt_pkg::conv_t conv,
    // digital comparators
    output logic [3:0] cmp_sample_use,
    input wire logic [3:0] cmp_hit,
    // interrupts
    output logic adc_irq_req,
    output logic irq
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    adc_filt_pkg::filt_cfg_t cfg [4];          // filter control fields
    logic [15:0] mask_low [4];                  // channel_compare_mask 15..0
    logic [9:0] mask_high [4];                  // channel_compare_mask 25..16
    logic [4:0] event_channel_number [4];       // last comparator event channel
    logic [7:0] irq_status;                     // 3..0 filter ready, 7..4 comparator
    logic [7:0] irq_mask;
    logic [15:0] result [4];
    logic [3:0] rdy;
    logic [3:0] done;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire logic setup = psel && !penable;
    wire logic access = psel && penable;
    wire logic wr = access && pwrite;
    wire logic rd_access = access && !pwrite;
    wire logic [1:0] inst = paddr[5:4];
    wire logic [1:0] evt_idx = paddr[3:2];      // comparator of an event channel word
    wire logic [7:0] word_ofs = {4'h0, paddr[3:0]};
    wire logic in_inst = (paddr[7:6] == 2'b00);
    wire logic in_evt = (paddr[7:4] == adc_filt_pkg::OFS_EVT_CHAN[7:4]);
    wire logic hit_status = (paddr == adc_filt_pkg::OFS_IRQ_STATUS);
    wire logic hit_mask = (paddr == adc_filt_pkg::OFS_IRQ_MASK);
    wire logic aligned = (paddr[1:0] == 2'b00);
    wire logic mapped = aligned && (in_inst || in_evt || hit_status || hit_mask);
    wire logic hit_ctrl = in_inst && (word_ofs == adc_filt_pkg::OFS_FILT_CTRL);
    wire logic hit_data = in_inst && (word_ofs == adc_filt_pkg::OFS_FILT_DATA);
    wire logic hit_mlow = in_inst && (word_ofs == adc_filt_pkg::OFS_MASK_LOW);
    wire logic hit_mhigh = in_inst && (word_ofs == adc_filt_pkg::OFS_MASK_HIGH);

    // zero-wait slave: every access ends in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // control word as read: bits 7-5 are not implemented
    function automatic logic [15:0] ctrl_word(adc_filt_pkg::filt_cfg_t c, logic r);
        logic [15:0] w;
        w = adc_filt_pkg::RESET_WORD;
        w[adc_filt_pkg::CTRL_ON_BIT] = c.filter_on;
        w[adc_filt_pkg::CTRL_MODE_LSB +: 2] = c.mode;
        w[adc_filt_pkg::CTRL_RATIO_LSB +: 3] = c.sample_ratio_sel;
        w[adc_filt_pkg::CTRL_IRQ_BIT] = c.filter_irq_allow;
        w[adc_filt_pkg::CTRL_RDY_BIT] = r;
        w[adc_filt_pkg::CTRL_SEL_LSB +: 5] = c.filter_input_sel;
        return w;
    endfunction

    // ------------------------------------------------------------------
    // read mux, sampled in the setup cycle so data stand in the access cycle
    // ------------------------------------------------------------------
    wire logic [15:0] rd_inst =
        hit_ctrl ? ctrl_word(cfg[inst], rdy[inst]) :
        hit_data ? result[inst] :
        hit_mlow ? mask_low[inst] :
        hit_mhigh ? {6'h00, mask_high[inst]} : 16'h0000;
    wire logic [31:0] next_prdata =
        !mapped ? 32'h0000_0000 :
        in_inst ? {16'h0000, rd_inst} :
        in_evt ? {27'h0, event_channel_number[evt_idx]} :
        hit_status ? {24'h0, irq_status} : {24'h0, irq_mask};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------------
    // per instance: registers, filter, comparator channel gate
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < adc_filt_pkg::NUM_INST; g++) begin : gen_inst
            wire logic sel_me = (inst == 2'(g));
            wire logic wr_ctrl = wr && hit_ctrl && sel_me;
            logic fresh;                // result replaced at this read's setup edge
            // a result that lands after the read data were taken keeps its flag
            wire logic rd_data = rd_access && hit_data && sel_me && !fresh;

            // remember a completion at the setup edge of a read
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    fresh <= 1'b0;
                end else begin
                    fresh <= setup && done[g];
                end
            end
            // channel mask as one 26-bit vector
            wire logic [25:0] chan_mask = {mask_high[g], mask_low[g]};
            // codes 26..31 select nothing
            wire logic sample_hit = conv.valid &&
                (conv.chan == cfg[g].filter_input_sel) && (conv.chan < 5'd26);

            // a comparator sees only results whose mask bit is set
            assign cmp_sample_use[g] = conv.valid && (conv.chan < 5'd26) &&
                                       chan_mask[conv.chan];

            // control register write; ready is not writable
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    cfg[g] <= '0;
                end else if (wr_ctrl) begin
                    cfg[g].filter_on <= pwdata[adc_filt_pkg::CTRL_ON_BIT];
                    cfg[g].mode <= pwdata[adc_filt_pkg::CTRL_MODE_LSB +: 2];
                    cfg[g].sample_ratio_sel <=
                        pwdata[adc_filt_pkg::CTRL_RATIO_LSB +: 3];
                    cfg[g].filter_irq_allow <= pwdata[adc_filt_pkg::CTRL_IRQ_BIT];
                    cfg[g].filter_input_sel <=
                        pwdata[adc_filt_pkg::CTRL_SEL_LSB +: 5];
                end
            end

            // comparator masks; high word keeps only ten bits
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    mask_low[g] <= 16'h0000;
                    mask_high[g] <= 10'h000;
                end else if (wr && sel_me && hit_mlow) begin
                    mask_low[g] <= pwdata[15:0];
                end else if (wr && sel_me && hit_mhigh) begin
                    mask_high[g] <= pwdata[adc_filt_pkg::MASK_HIGH_W-1:0];
                end
            end

            // comparator event: remember which channel fired
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    event_channel_number[g] <= 5'h00;
                end else if (cmp_hit[g] && cmp_sample_use[g]) begin
                    event_channel_number[g] <= conv.chan;
                end
            end

            oversample_filter u_filter (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .cfg(cfg[g]),
                .sample_valid(sample_hit),
                .sample(conv.data),
                .rdy_clear(rd_data),
                .result(result[g]),
                .rdy(rdy[g]),
                .done(done[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    wire logic [3:0] cmp_evt = cmp_hit & cmp_sample_use;
    wire logic [7:0] irq_set = {cmp_evt, done};
    wire logic status_read = rd_access && hit_status;
    logic [3:0] allow;
    always_comb begin
        for (int i = 0; i < adc_filt_pkg::NUM_INST; i++) begin
            allow[i] = cfg[i].filter_irq_allow;
        end
    end

    // sticky status; a read clears only the bits it returned, so an event
    // landing after the setup edge is not lost
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_status <= 8'h00;
        end else begin
            irq_status <= (status_read ? (irq_status & ~prdata[7:0]) : irq_status) | irq_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_mask <= 8'h00;
        end else if (wr && hit_mask) begin
            irq_mask <= pwdata[7:0];
        end
    end

    // shared adc request follows the ready flags of allowed filters
    assign adc_irq_req = |(rdy & allow);
    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_IRQ_ALLOW: assert property (done[0] && allow[0] && !wr |=> adc_irq_req)
        else $error("shared request missing after allowed result");
    AST_NO_REQ_WHEN_BLOCKED: assert property (allow == 4'h0 |-> !adc_irq_req)
        else $error("request raised with no filter allowed");
    AST_MASK_HIGH_ZERO: assert property (setup && !pwrite && hit_mhigh
                                         |=> prdata[31:10] == 22'h0)
        else $error("unimplemented mask bits read non-zero");
    AST_CTRL_RESV_ZERO: assert property (setup && !pwrite && hit_ctrl
                                         |=> prdata[7:5] == 3'h0)
        else $error("control bits 7-5 read non-zero");
    AST_EVT_CHAN: assert property (cmp_hit[0] && cmp_sample_use[0]
                                   |=> event_channel_number[0] == $past(conv.chan))
        else $error("comparator event channel not recorded");
    AST_MASK_GATES: assert property (conv.valid && conv.chan < 5'd16
                                     && !mask_low[1][conv.chan[3:0]]
                                     |-> !cmp_sample_use[1])
        else $error("masked channel fed to comparator");

endmodule

// *** hw/oversample_filter.sv ***
// one oversampling / averaging filter instance
`timescale 1ns/10ps
module oversample_filter (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // configuration and samples
    input wire adc_filt_pkg::filt_cfg_t cfg,
    input wire logic sample_valid,
    input wire logic [adc_filt_pkg::SAMPLE_W-1:0] sample,
    // result side
    input wire logic rdy_clear,
    output logic [15:0] result,
    output logic rdy,
    output logic done
);

    // ------------------------------------------------------------------
    // ratio decode
    // ------------------------------------------------------------------
    wire logic is_avg = (cfg.mode == adc_filt_pkg::MODE_AVERAGE);
    // averaging code 010 is taken as 8x, so log2 is simply code plus one
    wire logic [3:0] log2_n = is_avg ? ({1'b0, cfg.sample_ratio_sel} + 4'h1)
                                     : adc_filt_pkg::OVS_LOG2[cfg.sample_ratio_sel];
    // oversampling keeps half the extra bits: 12.1 up to 12.4
    wire logic [3:0] shift = is_avg ? log2_n : {1'b0, log2_n[3:1]};
    wire logic [adc_filt_pkg::CNT_W-1:0] last_count =
        adc_filt_pkg::CNT_W'((10'h001 << log2_n) - 10'h001);

    logic [adc_filt_pkg::ACC_W-1:0] acc;        // running sum
    logic [adc_filt_pkg::CNT_W-1:0] count;      // samples taken so far
    wire logic [adc_filt_pkg::ACC_W-1:0] next_acc = acc + adc_filt_pkg::ACC_W'(sample);
    wire logic take = cfg.filter_on && sample_valid;
    assign done = take && (count == last_count);

    // ------------------------------------------------------------------
    // accumulator and counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n || !cfg.filter_on) begin
            acc <= '0;
            count <= '0;
        end else if (done) begin
            // restart from zero after the last sample
            acc <= '0;
            count <= '0;
        end else if (take) begin
            acc <= next_acc;
            count <= count + 9'h001;
        end
    end

    // ------------------------------------------------------------------
    // result word and ready flag; a new result wins over a read clear
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result <= '0;
        end else if (done) begin
            result <= 16'(next_acc >> shift);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || !cfg.filter_on) begin
            rdy <= 1'b0;
        end else if (done) begin
            rdy <= 1'b1;
        end else if (rdy_clear) begin
            rdy <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_result_done;
        done ##1 rdy;
    endsequence

    AST_OFF_CLEARS_RDY: assert property (!cfg.filter_on |=> !rdy)
        else $error("ready flag set while filter disabled");
    AST_DONE_SETS_RDY: assert property (done |-> s_result_done)
        else $error("ready flag not set after result");
    AST_READ_CLEARS_RDY: assert property (rdy_clear && !done |=> !rdy)
        else $error("ready flag survived data read");
    AST_AVG_12BIT: assert property (done && is_avg |=> result[15:12] == 4'h0)
        else $error("averaged result wider than 12 bits");
    AST_OVS_13BIT: assert property (done && !is_avg && log2_n <= 4'h2
                                    |=> result[15:13] == 3'h0)
        else $error("2x or 4x result wider than 13 bits");

endmodule
